// ---- hdl/icap_pkg.sv ----
/*
  icap_pkg: register indices, field layouts, reset values and counts
  of the capture block with its paired time base.
  Assumes a 32-bit APB slave, one register per aligned word.
*/
package icap_pkg;

  // register indices; the byte address is four times the index
  localparam logic [11:0] IDX_TMR_LO   = 12'h106; // timer_low_count
  localparam logic [11:0] IDX_HOLD     = 12'h108; // upper_word_holding
  localparam logic [11:0] IDX_TMR_HI   = 12'h10a; // timer_high_count
  localparam logic [11:0] IDX_PR_LO    = 12'h10c; // period_low
  localparam logic [11:0] IDX_PR_HI    = 12'h10e; // period_high
  localparam logic [11:0] IDX_TCON_LO  = 12'h110; // timer_low_control
  localparam logic [11:0] IDX_TCON_HI  = 12'h112; // timer_high_control
  localparam logic [11:0] IDX_IRQ_STAT = 12'h084; // irq_status_reg_zero
  localparam logic [11:0] IDX_IRQ_EN   = 12'h08c; // irq_enable_reg_zero
  localparam logic [11:0] IDX_CAP_BASE = 12'h140; // channel 0 buffer

  // reset values and writable masks
  localparam logic [15:0] PERIOD_RST    = 16'hffff;
  localparam logic [15:0] CTL_RST       = 16'h0000;
  localparam logic [15:0] TCON_LO_WMASK = 16'ha07a;
  localparam logic [15:0] TCON_HI_WMASK = 16'ha072;
  localparam logic [15:0] CAP_CTL_WMASK = 16'h20e7;

  // interrupt bit positions, channel limit and full-buffer fill count
  localparam int unsigned TB_IRQ_BIT   = 7;
  localparam int unsigned LO_IRQ_BIT   = 6;
  localparam int unsigned CAP_IRQ_BASE = 8;
  localparam int unsigned MAX_CH       = 8;
  localparam logic [2:0]  FIFO_FULL    = 3'h4;

  // timer prescaler terminal counts (1, 8, 64, 256)
  localparam logic [7:0] PS_LAST_1   = 8'h00;
  localparam logic [7:0] PS_LAST_8   = 8'h07;
  localparam logic [7:0] PS_LAST_64  = 8'h3f;
  localparam logic [7:0] PS_LAST_256 = 8'hff;
  // capture prescaler terminal counts (every 4th, every 16th)
  localparam logic [3:0] CPS_LAST_4  = 4'h3;
  localparam logic [3:0] CPS_LAST_16 = 4'hf;

  // capture modes
  typedef enum logic [2:0] {
    CM_OFF    = 3'h0,
    CM_BOTH   = 3'h1,
    CM_FALL   = 3'h2,
    CM_RISE   = 3'h3,
    CM_RISE4  = 3'h4,
    CM_RISE16 = 3'h5,
    CM_RSV    = 3'h6,
    CM_WAKE   = 3'h7
  } icap_cap_mode_e;

  // timer control word layout
  typedef struct packed {
    logic       timer_on;
    logic       rsv14;
    logic       stop_in_idle;
    logic [5:0] rsv12_7;
    logic       gated_accumulate_enable;
    logic       prescale_select_hi;
    logic       prescale_select_lo;
    logic       joined_32bit_select;
    logic       rsv2;
    logic       clock_source_select;
    logic       rsv0;
  } icap_tmr_ctl_s;

  // capture channel control word layout
  typedef struct packed {
    logic [1:0]     rsv15_14;
    logic           capture_stop_in_idle;
    logic [4:0]     rsv12_8;
    logic           capture_timer_select;
    logic [1:0]     captures_per_interrupt;
    logic           capture_overflow_flag;
    logic           capture_buf_nonempty_bit;
    icap_cap_mode_e capture_mode_field;
  } icap_cap_ctl_s;

endpackage : icap_pkg

// ---- hdl/icap_top.sv ----
/*
  icap_top: input capture channels with their shared 16/32-bit
  time base, registers on APB, one level interrupt.
  Assumes pins are asynchronous to pclk; sleep comes as a level.
*/
`timescale 1ns/1ps
// Notes on behaviour
// R1: time base halts during processor sleep
// R2: joined match or gate fall sets flag
// R3: time base flag sticky until software clears
// R4: time base irq forwarded only when enabled
// R5: holding register serves 32-bit coherent access
// R6: low read latches high; low write loads
// R7: up to eight channels, own control each
// R8: mode selects fall, rise, 4th, 16th, both
// R9: select bit 7 picks timer, high default
// R10: channel prescaler cleared when off, reset
// R11: four-entry 16-bit buffer per channel
// R12: not-empty set until all entries read
// R13: read returns oldest, rest advance
// R14: fifth event when full sets overflow
// R15: after overflow ignore events until emptied
// R16: software must not trust empty reads
// R17: both-edge mode: flag each edge, no overflow
// R18: event stores selected timer count at tail
// R19: channel flag on capture, irq if enabled
module icap_top
  import icap_pkg::*;
#(
  parameter int unsigned NUM_CH = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [15:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  input  wire logic [NUM_CH-1:0] cap_pin,
  input  wire logic              timer_clk_pin,
  input  wire logic              cpu_sleep,
  output logic                   irq
);

  // refuse channel counts the interrupt layout cannot hold
  if (NUM_CH < 1 || NUM_CH > MAX_CH) begin : g_chk
    $error("icap_top: NUM_CH must be 1 to 8");
  end

  localparam int unsigned SW = NUM_CH + 2;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [SW-1:0] pin_meta_reg;  // first stage, read only by second
  logic [SW-1:0] pin_sync_reg;  // safe level
  logic [SW-1:0] pin_prev_reg;  // for edge detection
  logic          sleep_s;       // processor asleep
  logic          tck_s;         // gate or clock pin level
  logic          tck_rise;
  logic          tck_fall;

  // two flops on every pin, a third for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      pin_prev_reg <= '0;
    end else begin
      pin_meta_reg <= {cpu_sleep, timer_clk_pin, cap_pin};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign sleep_s  = pin_sync_reg[SW-1];
  assign tck_s    = pin_sync_reg[NUM_CH];
  assign tck_rise = tck_s & ~pin_prev_reg[NUM_CH];
  assign tck_fall = ~tck_s & pin_prev_reg[NUM_CH];

  //////////////////////////////////////////////////////////////////////
  // apb decode
  logic [11:0] idx;        // register index
  logic [15:0] wd;         // write data, low half
  logic        acc_first;  // first access cycle: read sampled
  logic        rd_fire;    // read side effects
  logic        wr_fire;    // write takes effect
  logic        hit;        // mapped address
  logic [15:0] rdata;      // read mux

  assign idx       = paddr[13:2];
  assign wd        = pwdata[15:0];
  assign acc_first = psel & penable & ~pready;
  assign rd_fire   = acc_first & ~pwrite & hit;
  assign wr_fire   = psel & penable & pready & pwrite & hit;

  // answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc_first;
      pslverr <= acc_first & ~hit;
      if (acc_first & ~pwrite) begin
        prdata <= {16'h0000, rdata};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // time base registers
  logic [15:0]   cnt_lo_reg;
  logic [15:0]   cnt_hi_reg;
  logic [15:0]   hold_reg;
  logic [15:0]   pr_lo_reg;
  logic [15:0]   pr_hi_reg;
  logic [15:0]   tcon_lo_reg;
  logic [15:0]   tcon_hi_reg;
  logic [7:0]    ps_lo_reg;
  logic [7:0]    ps_hi_reg;
  icap_tmr_ctl_s lo_ctl;
  icap_tmr_ctl_s hi_ctl;
  logic          joined;
  logic          src_lo;
  logic          src_hi;
  logic          tick_lo;
  logic          tick_hi;
  logic          match32;
  logic          gate_fall;
  logic          tb_set;
  logic          lo_set;

  function automatic logic [7:0] ps_last(input logic [1:0] s);
    case (s)
      2'b00:   return PS_LAST_1;
      2'b01:   return PS_LAST_8;
      2'b10:   return PS_LAST_64;
      default: return PS_LAST_256;
    endcase
  endfunction : ps_last

  assign lo_ctl = icap_tmr_ctl_s'(tcon_lo_reg);
  assign hi_ctl = icap_tmr_ctl_s'(tcon_hi_reg);
  assign joined = lo_ctl.joined_32bit_select;
  // no clocks reach the time base while asleep
  assign src_lo = lo_ctl.timer_on & ~sleep_s &                    // R1
                  (lo_ctl.clock_source_select ? tck_rise :
                   (~lo_ctl.gated_accumulate_enable | tck_s));
  assign src_hi = hi_ctl.timer_on & ~sleep_s & ~joined;           // R1
  assign tick_lo = src_lo & (ps_lo_reg == ps_last(
    {lo_ctl.prescale_select_hi, lo_ctl.prescale_select_lo}));
  assign tick_hi = src_hi & (ps_hi_reg == ps_last(
    {hi_ctl.prescale_select_hi, hi_ctl.prescale_select_lo}));
  assign match32 = {cnt_hi_reg, cnt_lo_reg} == {pr_hi_reg, pr_lo_reg};
  assign gate_fall = lo_ctl.timer_on & lo_ctl.gated_accumulate_enable &
                     ~lo_ctl.clock_source_select & tck_fall;
  assign tb_set = joined ? ((tick_lo & match32) | gate_fall)       // R2
                         : (tick_hi & (cnt_hi_reg == pr_hi_reg));
  assign lo_set = ~joined &
                  ((tick_lo & (cnt_lo_reg == pr_lo_reg)) | gate_fall);

  // prescalers, cleared by a write of count or control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_lo_reg <= 8'h00;
      ps_hi_reg <= 8'h00;
    end else begin
      if (wr_fire & (idx == IDX_TMR_LO | idx == IDX_TCON_LO)) begin
        ps_lo_reg <= 8'h00;
      end else if (src_lo) begin
        ps_lo_reg <= tick_lo ? 8'h00 : ps_lo_reg + 8'h01;
      end
      if (wr_fire & (idx == IDX_TMR_HI | idx == IDX_TCON_HI)) begin
        ps_hi_reg <= 8'h00;
      end else if (src_hi) begin
        ps_hi_reg <= tick_hi ? 8'h00 : ps_hi_reg + 8'h01;
      end
    end
  end

  // counters: joined pair or two independent halves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_lo_reg <= 16'h0000;
      cnt_hi_reg <= 16'h0000;
    end else begin
      if (wr_fire & idx == IDX_TMR_HI) begin
        cnt_hi_reg <= wd;
      end else if (tick_hi) begin
        cnt_hi_reg <= (cnt_hi_reg == pr_hi_reg) ? 16'h0000
                                                 : cnt_hi_reg + 16'h0001;
      end
      if (wr_fire & idx == IDX_TMR_LO) begin
        cnt_lo_reg <= wd;
        if (joined) begin
          cnt_hi_reg <= hold_reg;                                 // R6
        end
      end else if (tick_lo & joined) begin
        {cnt_hi_reg, cnt_lo_reg} <= match32 ? 32'h0000_0000
          : {cnt_hi_reg, cnt_lo_reg} + 32'h0000_0001;
      end else if (tick_lo) begin
        cnt_lo_reg <= (cnt_lo_reg == pr_lo_reg) ? 16'h0000
                                                 : cnt_lo_reg + 16'h0001;
      end
    end
  end

  // holding word: latched on low read, written directly otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg <= 16'h0000;
    end else if (rd_fire & idx == IDX_TMR_LO) begin
      hold_reg <= cnt_hi_reg;                                     // R5
    end else if (wr_fire & idx == IDX_HOLD) begin
      hold_reg <= wd;                                             // R6
    end
  end

  // period and control words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pr_lo_reg   <= PERIOD_RST;
      pr_hi_reg   <= PERIOD_RST;
      tcon_lo_reg <= CTL_RST;
      tcon_hi_reg <= CTL_RST;
    end else if (wr_fire) begin
      if (idx == IDX_PR_LO)   pr_lo_reg   <= wd;
      if (idx == IDX_PR_HI)   pr_hi_reg   <= wd;
      if (idx == IDX_TCON_LO) tcon_lo_reg <= wd & TCON_LO_WMASK;
      if (idx == IDX_TCON_HI) tcon_hi_reg <= wd & TCON_HI_WMASK;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // capture channels
  logic [15:0]       head   [NUM_CH];  // oldest entry per channel
  logic [15:0]       con_rd [NUM_CH];  // control read value
  logic [NUM_CH-1:0] cap_set;          // channel flag events

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch                // R7
    logic [15:0]   ctl_reg;
    logic [15:0]   fifo_reg [4];                                  // R11
    logic [2:0]    fill_reg;
    logic          ovf_reg;
    logic [3:0]    pre_reg;
    logic [1:0]    icnt_reg;
    icap_cap_ctl_s ctl;
    logic          rise;
    logic          fall;
    logic          ev;
    logic          push;
    logic          pop;
    logic          flag_ev;
    logic [15:0]   cap_val;
    logic [11:0]   buf_idx;

    assign buf_idx = 12'(IDX_CAP_BASE + 2 * c);
    assign ctl  = icap_cap_ctl_s'(ctl_reg);
    assign rise = pin_sync_reg[c] & ~pin_prev_reg[c];
    assign fall = ~pin_sync_reg[c] & pin_prev_reg[c];

    // qualifying event per mode; only wake mode runs asleep
    always_comb begin
      case (ctl.capture_mode_field)                               // R8
        CM_BOTH:   ev = rise | fall;
        CM_FALL:   ev = fall;
        CM_RISE:   ev = rise;
        CM_WAKE:   ev = rise;
        CM_RISE4:  ev = rise & (pre_reg == CPS_LAST_4);
        CM_RISE16: ev = rise & (pre_reg == CPS_LAST_16);
        default:   ev = 1'b0;
      endcase
      if (sleep_s & ctl.capture_mode_field != CM_WAKE) ev = 1'b0;
    end

    // low timer when the select bit is set, high timer otherwise
    assign cap_val = ctl.capture_timer_select ? cnt_lo_reg   // R9
                                              : cnt_hi_reg;
    assign pop  = rd_fire & idx == buf_idx & fill_reg != 3'h0;
    assign push = ev & ~ovf_reg & ~sleep_s & fill_reg != FIFO_FULL;
    assign flag_ev = (ctl.capture_mode_field == CM_BOTH |
                      ctl.capture_mode_field == CM_WAKE) ? ev : push;

    // control word, status bits merged on read
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctl_reg <= CTL_RST;
      end else if (wr_fire & idx == buf_idx + 12'h001) begin
        ctl_reg <= wd & CAP_CTL_WMASK;
      end
    end

    // edge prescaler, cleared whenever the channel is off
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pre_reg <= 4'h0;                                          // R10
      end else if (ctl.capture_mode_field == CM_OFF) begin
        pre_reg <= 4'h0;                                          // R10
      end else if (rise & ctl.capture_mode_field == CM_RISE4) begin
        pre_reg <= (pre_reg == CPS_LAST_4) ? 4'h0 : pre_reg + 4'h1;
      end else if (rise & ctl.capture_mode_field == CM_RISE16) begin
        pre_reg <= pre_reg + 4'h1;
      end
    end

    // shift buffer: pop advances, push lands at the tail
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        fill_reg <= 3'h0;
        for (int i = 0; i < 4; i++) fifo_reg[i] <= 16'h0000;
      end else begin
        if (pop) begin
          for (int i = 0; i < 3; i++) begin
            fifo_reg[i] <= fifo_reg[i+1];                         // R13
          end
        end
        if (push) begin
          fifo_reg[2'(pop ? fill_reg - 3'h1 : fill_reg)] <= cap_val; // R18
        end
        fill_reg <= fill_reg + {2'b00, push} - {2'b00, pop};
      end
    end

    // overflow: set on an event into a full buffer outside both-edge mode, held till empty
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ovf_reg <= 1'b0;
      end else if (ev & fill_reg == FIFO_FULL &
                   ctl.capture_mode_field != CM_BOTH) begin       // R17
        ovf_reg <= 1'b1;                                          // R14
      end else if (fill_reg == 3'h0) begin
        ovf_reg <= 1'b0;                                          // R15
      end
    end

    // interrupt every n-th capture, every edge in both-edge mode and every rise in wake mode
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        icnt_reg <= 2'b00;
      end else if (ctl.capture_mode_field == CM_OFF) begin
        icnt_reg <= 2'b00;
      end else if (push & ctl.capture_mode_field != CM_BOTH) begin
        icnt_reg <= (icnt_reg == ctl.captures_per_interrupt) ? 2'b00
                                                  : icnt_reg + 2'b01;
      end
    end

    assign cap_set[c] = flag_ev &                                 // R19
      (ctl.capture_mode_field == CM_BOTH |                        // R17
       ctl.capture_mode_field == CM_WAKE |
       icnt_reg == ctl.captures_per_interrupt);
    assign head[c] = fifo_reg[0];
    assign con_rd[c] = ctl_reg | {11'h000, ovf_reg,
                                  fill_reg != 3'h0, 3'h0};        // R12
  end

  //////////////////////////////////////////////////////////////////////
  // interrupt status and enable
  logic [15:0] irq_stat_reg;  // sticky flags, cleared by read
  logic [15:0] irq_en_reg;    // enables
  logic [15:0] set_vec;

  always_comb begin
    set_vec = 16'h0000;
    set_vec[TB_IRQ_BIT] = tb_set;
    set_vec[LO_IRQ_BIT] = lo_set;
    set_vec[CAP_IRQ_BASE +: NUM_CH] = cap_set;
  end

  // a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= 16'h0000;
    end else if (rd_fire & idx == IDX_IRQ_STAT) begin
      irq_stat_reg <= set_vec;                                    // R3
    end else begin
      irq_stat_reg <= irq_stat_reg | set_vec;                     // R3
    end
  end

  // enable register and the gated output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_reg <= 16'h0000;
      irq        <= 1'b0;
    end else begin
      if (wr_fire & idx == IDX_IRQ_EN) irq_en_reg <= wd;
      irq <= |(irq_stat_reg & irq_en_reg);                        // R4
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    rdata = 16'h0000;
    hit   = 1'b1;
    case (idx)
      IDX_TMR_LO:   rdata = cnt_lo_reg;
      IDX_HOLD:     rdata = hold_reg;
      IDX_TMR_HI:   rdata = cnt_hi_reg;
      IDX_PR_LO:    rdata = pr_lo_reg;
      IDX_PR_HI:    rdata = pr_hi_reg;
      IDX_TCON_LO:  rdata = tcon_lo_reg;
      IDX_TCON_HI:  rdata = tcon_hi_reg;
      IDX_IRQ_STAT: rdata = irq_stat_reg;
      IDX_IRQ_EN:   rdata = irq_en_reg;
      default:      hit   = 1'b0;
    endcase
    for (int c = 0; c < NUM_CH; c++) begin
      if (idx == 12'(IDX_CAP_BASE + 2 * c)) begin
        rdata = head[c];
        hit   = 1'b1;
      end
      if (idx == 12'(IDX_CAP_BASE + 2 * c + 1)) begin
        rdata = con_rd[c];
        hit   = 1'b1;
      end
    end
    if (paddr[1:0] != 2'b00 || paddr[15:14] != 2'b00) begin
      hit   = 1'b0;
      rdata = 16'h0000;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  property p_sleep_stop;
    sleep_s && !wr_fire |=> $stable(cnt_lo_reg);
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) // R1
    else $error("time base moved in sleep");

  property p_tb_match;
    joined && tick_lo && match32 |=> irq_stat_reg[TB_IRQ_BIT];
  endproperty
  a_tb_match: assert property (p_tb_match) // R2
    else $error("32-bit match did not set flag");

  property p_tb_sticky;
    irq_stat_reg[TB_IRQ_BIT] && !(rd_fire && idx == IDX_IRQ_STAT)
      |=> irq_stat_reg[TB_IRQ_BIT];
  endproperty
  a_tb_sticky: assert property (p_tb_sticky) // R3
    else $error("flag dropped without software");

  property p_irq_gate;
    !(|(irq_stat_reg & irq_en_reg)) |=> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) // R4
    else $error("interrupt without enabled flag");

  property p_hold_latch;
    rd_fire && idx == IDX_TMR_LO |=> hold_reg == $past(cnt_hi_reg);
  endproperty
  a_hold_latch: assert property (p_hold_latch) // R6
    else $error("low read did not latch high word");

  property p_pre_clear;
    g_ch[0].ctl.capture_mode_field == CM_OFF |=> g_ch[0].pre_reg == 4'h0;
  endproperty
  a_pre_clear: assert property (p_pre_clear) // R10
    else $error("prescaler not cleared when off");

  property p_nonempty;
    con_rd[0][3] == (g_ch[0].fill_reg != 3'h0)
      && g_ch[0].fill_reg <= FIFO_FULL;
  endproperty
  a_nonempty: assert property (p_nonempty) // R12
    else $error("not-empty flag or fill wrong");

  property p_overflow;
    g_ch[0].ev && g_ch[0].fill_reg == FIFO_FULL && !g_ch[0].ovf_reg
      && g_ch[0].ctl.capture_mode_field != CM_BOTH
      |=> g_ch[0].ovf_reg && g_ch[0].fill_reg == FIFO_FULL;
  endproperty
  a_overflow: assert property (p_overflow) // R14
    else $error("fifth event did not overflow");

  property p_ovf_ignore;
    g_ch[0].ovf_reg |-> !g_ch[0].push;
  endproperty
  a_ovf_ignore: assert property (p_ovf_ignore) // R15
    else $error("capture stored during overflow");

endmodule : icap_top

// ---- tb/icap_pin_src.sv ----
/*
  icap_pin_src: far-side pin source, one high pulse per request.
  Assumes one-cycle requests spaced at least 8 cycles apart.
*/
`timescale 1ns/1ps
module icap_pin_src #(
  parameter int unsigned W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] rise_req,
  output logic      [W-1:0] cap_pin
);
  logic [2:0] hold_cnt [W]; // cycles left high
  //////////////////////////////////////////////////////////////
  // pin rises on request, falls four cycles later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_pin <= '0;
      for (int i = 0; i < W; i++) hold_cnt[i] <= 3'h0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (rise_req[i]) begin
          cap_pin[i]  <= 1'b1;
          hold_cnt[i] <= 3'h4;
        end else if (hold_cnt[i] != 3'h0) begin
          hold_cnt[i] <= hold_cnt[i] - 3'h1;
          cap_pin[i]  <= (hold_cnt[i] != 3'h1);
        end
      end
    end
  end
endmodule : icap_pin_src

// ---- tb/icap_top_bench.sv ----
/*
  icap_top_bench: register-level tests of capture and time base.
  Assumes an APB slave that answers with pready; pins seen late.
*/
`timescale 1ns/1ps
module icap_top_bench;
  import icap_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, cpu_sleep, tck_pin;
  logic        pready, pslverr, irq;       // design outputs
  logic [15:0] paddr, rd, t0;              // address, read data
  logic [31:0] pwdata, prdata;
  logic [7:0]  cap_pin, rise_req;          // pins and pulse requests
  logic        er;                         // last error response
  int          miscompares, check_count, n;
  icap_cap_mode_e mode_tab [6] = '{CM_FALL, CM_RISE, CM_RISE4,
                                   CM_RISE16, CM_BOTH, CM_WAKE};
  int          need_tab [6] = '{1, 1, 4, 16, 1, 1}; // pulses until the first store
  int          store_tab [6] = '{1, 1, 1, 1, 2, 1}; // stores from the last pulse
  icap_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cap_pin(cap_pin), .timer_clk_pin(tck_pin), .cpu_sleep(cpu_sleep),
    .irq(irq));
  icap_pin_src #(.W(8)) pin_u (.pclk(pclk), .presetn(presetn),
    .rise_req(rise_req), .cap_pin(cap_pin));
  //////////////////////////////////////////////////////////////
  // one APB transfer; pready and data taken at the same rising edge
  task automatic xfer(input logic w, input logic [11:0] idx,
                      input logic [15:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, pready, 1'b1);
    end
    rd = prdata[15:0];
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // masked read compare
  task automatic rdm(input logic [11:0] idx, input logic [15:0] m,
                     input logic [15:0] exp);
    xfer(1'b0, idx, 16'h0000);
    chk(rd & m, exp);
  endtask : rdm
  // n pin pulses on channel ch
  task automatic pulse(input int ch, input int cnt);
    repeat (cnt) begin
      @(posedge pclk) rise_req[ch] <= 1'b1;
      @(posedge pclk) rise_req[ch] <= 1'b0;
      repeat (10) @(posedge pclk);
    end
  endtask : pulse
  task automatic irq_is(input logic v);
    for (n = 0; n < 60 && irq !== v; n++) @(negedge pclk);
    chk({15'h0000, irq}, {15'h0000, v});
  endtask : irq_is
  task automatic print_verdict();
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  //////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
  initial begin
    {presetn, psel, penable, pwrite, cpu_sleep, tck_pin} = 6'h00;
    {paddr, pwdata, rise_req} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdm(IDX_PR_LO, 16'hffff, PERIOD_RST);
    rdm(IDX_TCON_LO, 16'hffff, CTL_RST);
    xfer(1'b0, 12'h000, 16'h0000);
    chk({15'h0000, er}, 16'h0001);
    // channel 0 on the low timer, counts frozen with the timer off
    xfer(1'b1, IDX_IRQ_EN, 16'h0100);
    xfer(1'b1, 12'h141, 16'h0083);
    for (int k = 1; k <= 5; k++) begin
      xfer(1'b1, IDX_TMR_LO, 16'(k));
      pulse(0, 1);
    end
    irq_is(1'b1);
    rdm(IDX_IRQ_STAT, 16'h0100, 16'h0100);
    rdm(IDX_IRQ_STAT, 16'h0100, 16'h0000);
    irq_is(1'b0);
    rdm(12'h141, 16'h0018, 16'h0018);
    rdm(12'h140, 16'hffff, 16'h0001);
    rdm(12'h140, 16'hffff, 16'h0002);
    xfer(1'b1, IDX_TMR_LO, 16'h0009);
    pulse(0, 1);
    rdm(12'h140, 16'hffff, 16'h0003);
    rdm(12'h140, 16'hffff, 16'h0004);
    rdm(12'h141, 16'h0008, 16'h0000);
    // every mode except off and reserved on channel 1; no empty-buffer value is relied on
    for (int m = 0; m < 6; m++) begin
      xfer(1'b1, 12'h143, {13'h0000, mode_tab[m]});
      pulse(1, need_tab[m] - 1);
      rdm(12'h143, 16'h0008, 16'h0000);
      pulse(1, 1);
      rdm(12'h143, 16'h0008, 16'h0008);
      repeat (store_tab[m]) xfer(1'b0, 12'h142, 16'h0000);
      rdm(12'h143, 16'h0018, 16'h0000);
      xfer(1'b1, 12'h143, 16'h0000);
    end
    // joined time base: coherent access, match, sticky flag
    xfer(1'b1, IDX_TCON_LO, 16'h0008);
    xfer(1'b1, IDX_HOLD, 16'h0005);
    xfer(1'b1, IDX_TMR_LO, 16'h0000);
    rdm(IDX_TMR_HI, 16'hffff, 16'h0005);
    xfer(1'b1, IDX_HOLD, 16'h0009);
    rdm(IDX_TMR_LO, 16'hffff, 16'h0000);
    rdm(IDX_HOLD, 16'hffff, 16'h0005);
    xfer(1'b1, IDX_HOLD, 16'h0000);
    xfer(1'b1, IDX_TMR_LO, 16'h0000);
    xfer(1'b1, IDX_PR_HI, 16'h0000);
    xfer(1'b1, IDX_PR_LO, 16'h0003);
    xfer(1'b1, IDX_IRQ_EN, 16'h0080);
    xfer(1'b1, IDX_TCON_LO, 16'h8008);
    irq_is(1'b1);
    xfer(1'b1, IDX_TCON_LO, 16'h0008);
    xfer(1'b1, IDX_IRQ_EN, 16'h0000);
    repeat (20) @(negedge pclk);
    irq_is(1'b0);
    rdm(IDX_IRQ_STAT, 16'h0080, 16'h0080);
    rdm(IDX_IRQ_STAT, 16'h0080, 16'h0000);
    // sleep halts the running low timer
    xfer(1'b1, IDX_PR_LO, 16'hffff);
    xfer(1'b1, IDX_TCON_LO, 16'h8000);
    @(posedge pclk) cpu_sleep <= 1'b1;
    repeat (6) @(posedge pclk);
    xfer(1'b0, IDX_TMR_LO, 16'h0000);
    t0 = rd;
    repeat (10) @(posedge pclk);
    rdm(IDX_TMR_LO, 16'hffff, t0);
    @(posedge pclk) cpu_sleep <= 1'b0;
    repeat (10) @(posedge pclk);
    xfer(1'b0, IDX_TMR_LO, 16'h0000);
    chk({15'h0000, rd === t0}, 16'h0000);
    // joined gated mode: the gate's falling edge sets the flag
    xfer(1'b1, IDX_TCON_LO, 16'h8048);
    @(posedge pclk) tck_pin <= 1'b1;
    rdm(IDX_IRQ_STAT, 16'h0080, 16'h0000);
    @(posedge pclk) tck_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    rdm(IDX_IRQ_STAT, 16'h0080, 16'h0080);
    print_verdict();
  end
endmodule : icap_top_bench
